/* File: core/rcout_pkg.sv */
package rcout_pkg;
	localparam logic [31:0] RCOUT_CTRL_OFS    = 32'h0000_0000;
	localparam logic [31:0] RCOUT_SRC_OFS     = 32'h0000_0004;
	localparam logic [31:0] RCOUT_STAT_OFS    = 32'h0000_0008;
	localparam int          RCOUT_ADDR_W      = 4;
	localparam int          RCOUT_ON_BIT      = 7;
	localparam int          RCOUT_DUTY_HI     = 4;
	localparam int          RCOUT_DUTY_LO     = 3;
	localparam int          RCOUT_DIV_HI      = 2;
	localparam int          RCOUT_DIV_LO      = 0;
	localparam logic [7:0]  RCOUT_CTRL_RST    = 8'h10;
	localparam logic [7:0]  RCOUT_CTRL_MASK   = 8'h9F;
	localparam logic [2:0]  RCOUT_SRC_RST     = 3'h0;
	localparam int          RCOUT_STAT_OUT    = 0;
	localparam int          RCOUT_STAT_RUN    = 1;
	localparam int          RCOUT_STAT_CNT_LO = 8;
	localparam logic [2:0]  RCOUT_SRC_SYS     = 3'h0;
	localparam logic [2:0]  RCOUT_SRC_HF      = 3'h1;
	localparam logic [2:0]  RCOUT_SRC_LF      = 3'h2;
	localparam logic [2:0]  RCOUT_SRC_MF      = 3'h3;
	localparam logic [2:0]  RCOUT_SRC_SEC     = 3'h4;
	localparam int          RCOUT_NUM_EXT     = 4;
	localparam logic [2:0]  RCOUT_DIV_NONE    = 3'h0;
	localparam logic [1:0]  RCOUT_DUTY_ZERO   = 2'h0;
	localparam logic [8:0]  RCOUT_EDGE_BASE   = 9'h002;
endpackage

/* File: core/rcout_link_if.sv */
`timescale 1ns/1ps
interface rcout_link_if;
	logic       enable;
	logic [1:0] duty;
	logic [2:0] div;
	logic       sleep;
	logic       src_edge;
	logic       src_rise;
	logic       src_level;
	logic       src_sys;
	logic       out;
	logic       running;
	logic [7:0] count;
	modport ctrl (
		output enable, duty, div, sleep, src_edge, src_rise, src_level,
		src_sys,
		input  out, running, count
	);
	modport shaper (
		input  enable, duty, div, sleep, src_edge, src_rise, src_level,
		src_sys,
		output out, running, count
	);
endinterface

/* File: core/rcout_sync.sv */
`timescale 1ns/1ps
module rcout_sync (
	input  wire logic core_clk_in,
	input  wire logic reset_in,
	input  wire logic async_in,
	output logic      level_out,
	output logic      rise_out,
	output logic      edge_out
);
	logic meta_r;
	logic sync_r;
	logic prev_r;

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// edges are taken between the second and third stage only
	always_comb begin
		level_out = sync_r;
		rise_out  = sync_r & ~prev_r;
		edge_out  = sync_r ^ prev_r;
	end
endmodule

/* File: core/rcout_shaper.sv */
`timescale 1ns/1ps
module rcout_shaper
	import rcout_pkg::*;
(
	input  wire logic core_clk_in,
	input  wire logic reset_in,
	rcout_link_if.shaper lnk
);
	logic [8:0] last_edge;
	logic [8:0] high_edges;
	logic [7:0] cnt_nxt;
	logic       out_nxt;

	always_comb begin
		last_edge  = (RCOUT_EDGE_BASE << lnk.div) - 9'h001;
		high_edges = {7'h00, lnk.duty} << lnk.div;
		high_edges = high_edges >> 1;
		cnt_nxt    = ({1'b0, lnk.count} == last_edge) ? 8'h00
			: lnk.count + 8'h01;
		if (lnk.div == RCOUT_DIV_NONE) begin
			// undivided: follow the source, duty field ignored
			out_nxt = lnk.src_sys ? ~lnk.out : lnk.src_level;
		end else begin
			out_nxt = {1'b0, cnt_nxt} < high_edges;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in || !lnk.enable) begin
			// disable drops the pin on the same edge
			lnk.running <= 1'b0;
			lnk.count   <= 8'h00;
			lnk.out     <= 1'b0;
		end else if (lnk.sleep) begin
			// everything holds; resumes where it stopped
			lnk.running <= lnk.running;
		end else if (lnk.src_edge) begin
			if (!lnk.running) begin
				// start on a rising source edge only: no runt
				if (lnk.src_rise) begin
					lnk.running <= 1'b1;
					lnk.count   <= 8'h00;
					lnk.out     <= (lnk.div == RCOUT_DIV_NONE)
						|| (lnk.duty != RCOUT_DUTY_ZERO);
				end
			end else begin
				lnk.count <= cnt_nxt;
				lnk.out   <= out_nxt;
			end
		end
	end
endmodule

/* File: core/rcout_top.sv */
`timescale 1ns/1ps
module rcout_top
	import rcout_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        reset_in,
	input  wire logic        wb_cyc_i_in,
	input  wire logic        wb_stb_i_in,
	input  wire logic        wb_we_i_in,
	input  wire logic [31:0] wb_adr_i_in,
	input  wire logic [31:0] wb_dat_i_in,
	input  wire logic [3:0]  wb_sel_i_in,
	output logic [31:0]      wb_dat_o_out,
	output logic             wb_ack_o_out,
	input  wire logic        sleep_in,
	input  wire logic        high_freq_internal_osc_in,
	input  wire logic        low_freq_internal_osc_in,
	input  wire logic        mid_freq_internal_osc_in,
	input  wire logic        secondary_oscillator_in,
	output logic             ref_clock_out_pin_out,
	output logic             ref_clock_periph_out
);
	logic [7:0]               ref_clock_control_r;
	logic [2:0]               ref_clock_source_select_r;
	logic [31:0]              rd_data_nxt;
	logic                     ack_r;
	logic [31:0]              dat_r;
	logic                     req;
	logic                     wr_ctrl;
	logic                     wr_src;
	logic                     ref_clock_on_bit;
	logic [RCOUT_NUM_EXT-1:0] ext_pins;
	logic [RCOUT_NUM_EXT-1:0] ext_level;
	logic [RCOUT_NUM_EXT-1:0] ext_rise;
	logic [RCOUT_NUM_EXT-1:0] ext_edge;

	rcout_link_if lnk ();

	assign ext_pins = {secondary_oscillator_in, mid_freq_internal_osc_in,
		low_freq_internal_osc_in, high_freq_internal_osc_in};

	// each oscillator is foreign to core_clk_in and is synchronised first
	genvar gi;
	generate
		for (gi = 0; gi < RCOUT_NUM_EXT; gi++) begin : g_src
			rcout_sync u_sync (
				.core_clk_in (core_clk_in),
				.reset_in    (reset_in),
				.async_in    (ext_pins[gi]),
				.level_out   (ext_level[gi]),
				.rise_out    (ext_rise[gi]),
				.edge_out    (ext_edge[gi])
			);
		end
	endgenerate

	// wishbone decode; writable registers live in the low byte lane
	always_comb begin
		req      = wb_cyc_i_in & wb_stb_i_in & ~ack_r;
		// writes land on the ack edge, the one the master samples
		wr_ctrl  = wb_cyc_i_in & wb_stb_i_in & ack_r & wb_we_i_in
			& wb_sel_i_in[0] & (wb_adr_i_in == RCOUT_CTRL_OFS);
		wr_src   = wb_cyc_i_in & wb_stb_i_in & ack_r & wb_we_i_in
			& wb_sel_i_in[0] & (wb_adr_i_in == RCOUT_SRC_OFS);
	end

	always_comb begin
		rd_data_nxt = 32'h0000_0000;
		if (wb_adr_i_in == RCOUT_CTRL_OFS) begin
			// bits 6-5 read back zero
			rd_data_nxt[7:0] = ref_clock_control_r & RCOUT_CTRL_MASK;
		end else if (wb_adr_i_in == RCOUT_SRC_OFS) begin
			rd_data_nxt[2:0] = ref_clock_source_select_r;
		end else if (wb_adr_i_in == RCOUT_STAT_OFS) begin
			rd_data_nxt[RCOUT_STAT_OUT] = lnk.out;
			rd_data_nxt[RCOUT_STAT_RUN] = lnk.running;
			rd_data_nxt[RCOUT_STAT_CNT_LO +: 8] = lnk.count;
		end
	end

	// one-cycle registered ack; unmapped addresses ack with zero data
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= req;
			dat_r <= req ? rd_data_nxt : 32'h0000_0000;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			ref_clock_control_r <= RCOUT_CTRL_RST;
		end else if (wr_ctrl) begin
			// accepted even while running
			ref_clock_control_r <= wb_dat_i_in[7:0] & RCOUT_CTRL_MASK;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			ref_clock_source_select_r <= RCOUT_SRC_RST;
		end else if (wr_src) begin
			ref_clock_source_select_r <= wb_dat_i_in[2:0];
		end
	end

	// enable seen by the shaper is the value being written, so a clear
	// stops the output on the write edge rather than one later
	always_comb begin
		ref_clock_on_bit = wr_ctrl ? wb_dat_i_in[RCOUT_ON_BIT]
			: ref_clock_control_r[RCOUT_ON_BIT];
	end

	always_comb begin
		lnk.enable    = ref_clock_on_bit;
		// fields bypass too, so a start written with new settings
		// opens its first period with them and leaves no runt
		lnk.duty      = wr_ctrl ? wb_dat_i_in[RCOUT_DUTY_HI:RCOUT_DUTY_LO]
			: ref_clock_control_r[RCOUT_DUTY_HI:RCOUT_DUTY_LO];
		lnk.div       = wr_ctrl ? wb_dat_i_in[RCOUT_DIV_HI:RCOUT_DIV_LO]
			: ref_clock_control_r[RCOUT_DIV_HI:RCOUT_DIV_LO];
		lnk.sleep     = sleep_in;
		lnk.src_sys   = 1'b0;
		lnk.src_edge  = 1'b0;
		lnk.src_rise  = 1'b0;
		lnk.src_level = 1'b0;
		// unimplemented codes give no edges, so the output stalls
		unique case (ref_clock_source_select_r)
			RCOUT_SRC_SYS: begin
				// system clock: every cycle is one source half period
				lnk.src_sys  = 1'b1;
				lnk.src_edge = 1'b1;
				lnk.src_rise = 1'b1;
			end
			RCOUT_SRC_HF: begin
				lnk.src_edge  = ext_edge[0];
				lnk.src_rise  = ext_rise[0];
				lnk.src_level = ext_level[0];
			end
			RCOUT_SRC_LF: begin
				lnk.src_edge  = ext_edge[1];
				lnk.src_rise  = ext_rise[1];
				lnk.src_level = ext_level[1];
			end
			RCOUT_SRC_MF: begin
				lnk.src_edge  = ext_edge[2];
				lnk.src_rise  = ext_rise[2];
				lnk.src_level = ext_level[2];
			end
			RCOUT_SRC_SEC: begin
				lnk.src_edge  = ext_edge[3];
				lnk.src_rise  = ext_rise[3];
				lnk.src_level = ext_level[3];
			end
			default: begin
				lnk.src_edge = 1'b0;
			end
		endcase
	end

	rcout_shaper u_shaper (
		.core_clk_in (core_clk_in),
		.reset_in    (reset_in),
		.lnk         (lnk)
	);

	always_comb begin
		wb_ack_o_out          = ack_r;
		wb_dat_o_out          = dat_r;
		ref_clock_out_pin_out = lnk.out;
		ref_clock_periph_out  = lnk.out;
	end

	a_ack_single: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		wb_ack_o_out |=> !wb_ack_o_out)
		else $error("ack held longer than one cycle");

	a_ack_follows_req: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		(wb_cyc_i_in && wb_stb_i_in && !wb_ack_o_out) |=> wb_ack_o_out)
		else $error("request not acknowledged next cycle");

	a_reserved_zero: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		ref_clock_control_r[6:5] == 2'h0)
		else $error("reserved control bits set");

	a_duty_reset: assert property (@(posedge core_clk_in)
		$fell(reset_in) |-> ref_clock_control_r == RCOUT_CTRL_RST)
		else $error("control reset value wrong");

	a_disable_drop: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		(wr_ctrl && !wb_dat_i_in[RCOUT_ON_BIT])
		|=> !ref_clock_out_pin_out && lnk.count == 8'h00)
		else $error("output not stopped on disable");

	a_off_idle: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		!ref_clock_control_r[RCOUT_ON_BIT] && !ack_r
		|-> !ref_clock_out_pin_out && !lnk.running)
		else $error("disabled module not idle");

	a_sleep_freeze: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		sleep_in && ref_clock_on_bit && !wr_ctrl && !wr_src
		|=> $stable(ref_clock_out_pin_out) && $stable(lnk.count)
			&& $stable(ref_clock_control_r))
		else $error("state changed during sleep");

	a_start_high: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		(lnk.enable && !lnk.running && !sleep_in && lnk.src_rise
			&& lnk.duty != RCOUT_DUTY_ZERO)
		|=> ref_clock_out_pin_out && lnk.count == 8'h00)
		else $error("start did not open a full high phase");

	a_zero_duty: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		lnk.duty == RCOUT_DUTY_ZERO && lnk.div != RCOUT_DIV_NONE
		&& $stable(ref_clock_control_r) |=> !ref_clock_out_pin_out)
		else $error("zero duty produced a high output");

	a_sys_div2: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		lnk.running && lnk.src_sys && lnk.div == 3'h1
		&& lnk.duty == 2'h2 && !sleep_in && $stable(ref_clock_control_r)
		&& lnk.count == 8'h01 ##1 (!sleep_in && $stable(ref_clock_control_r))
		|-> lnk.count == 8'h02 && !ref_clock_out_pin_out)
		else $error("divide by two count or phase wrong");

	a_undiv_follow: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		lnk.running && !lnk.src_sys && lnk.div == RCOUT_DIV_NONE
		&& lnk.src_edge && !sleep_in && lnk.enable
		|=> ref_clock_out_pin_out == $past(lnk.src_level))
		else $error("undivided output not following source");

	a_pins_equal: assert property (@(posedge core_clk_in)
		disable iff (reset_in)
		ref_clock_out_pin_out == ref_clock_periph_out)
		else $error("pin and internal clock differ");
endmodule

/* File: dv/rcout_far_model.sv */
`timescale 1ns/1ps
module rcout_far_model #(
	parameter int HF_HALF  = 60,
	parameter int LF_HALF  = 200,
	parameter int MF_HALF  = 300,
	parameter int SEC_HALF = 400
) (
	input  wire logic pin_in,
	output logic      hf_out,
	output logic      lf_out,
	output logic      mf_out,
	output logic      sec_out,
	output int        rise_cnt_out
);
	// free-running oscillators, phase unrelated to the system clock
	initial begin
		hf_out = 1'b0;
		lf_out = 1'b0;
		mf_out = 1'b0;
		sec_out = 1'b0;
		rise_cnt_out = 0;
	end
	always #(HF_HALF) hf_out = ~hf_out;
	always #(LF_HALF) lf_out = ~lf_out;
	always #(MF_HALF) mf_out = ~mf_out;
	always #(SEC_HALF) sec_out = ~sec_out;
	// a consumer only sees rising edges of the pin
	always @(posedge pin_in) rise_cnt_out++;
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top import rcout_pkg::*;;
	typedef struct {
		logic [2:0] r;
		logic [1:0] d;
		int         hi;
		int         per;
	} rcout_row_type;
	rcout_row_type rows [11] = '{'{3'h1, 2'h2, 2, 4}, '{3'h1, 2'h1, 1, 4},
		'{3'h2, 2'h3, 6, 8}, '{3'h3, 2'h1, 4, 16}, '{3'h7, 2'h2, 128, 256},
		'{3'h0, 2'h3, 1, 2}, '{3'h0, 2'h1, 1, 2}, '{3'h4, 2'h2, 16, 32},
		'{3'h5, 2'h1, 16, 64}, '{3'h6, 2'h3, 96, 128}, '{3'h0, 2'h0, 1, 2}};
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic        slp = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] wdat = 32'h0;
	logic [3:0]  sel = 4'h0;
	logic [31:0] rdat;
	logic        ack;
	logic        pin;
	logic        per_o;
	logic        hf, lf, mf, sec;
	logic [31:0] q;
	logic [7:0]  c;
	int          err_count = 0;
	int          n_compared = 0;
	int          rises, r0, hi, per;
	logic        held;
	logic [31:0] q0;
	logic [3:0]  wsel = 4'hF;
	int          nr;
	// pin rises in 300 cycles at ratio 1, from the model's half periods
	int          ext_exp [6] = '{0, 50, 15, 10, 7, 0};

	always #20 clk = ~clk;

	rcout_top dut (.core_clk_in(clk), .reset_in(rst), .wb_cyc_i_in(cyc),
		.wb_stb_i_in(stb), .wb_we_i_in(we), .wb_adr_i_in(adr),
		.wb_dat_i_in(wdat), .wb_sel_i_in(sel), .wb_dat_o_out(rdat),
		.wb_ack_o_out(ack), .sleep_in(slp), .high_freq_internal_osc_in(hf),
		.low_freq_internal_osc_in(lf), .mid_freq_internal_osc_in(mf),
		.secondary_oscillator_in(sec), .ref_clock_out_pin_out(pin),
		.ref_clock_periph_out(per_o));
	rcout_far_model far (.pin_in(pin), .hf_out(hf), .lf_out(lf),
		.mf_out(mf), .sec_out(sec), .rise_cnt_out(rises));

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic wb(input logic w, input logic [31:0] a, d,
		output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= wsel;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50) chk("ack", 1, 0);
	endtask

	// one full period from the first rising edge; pin and copy must agree while high
	task automatic meas(output int h, p);
		int t;
		h = 0;
		p = 0;
		t = 0;
		while (pin !== 1'b0 && t < 600) begin @(negedge clk); t++; end
		while (pin !== 1'b1 && t < 600) begin @(negedge clk); t++; end
		while (pin === 1'b1 && p < 600) begin
			chk("copy", pin, per_o);
			@(negedge clk);
			h++;
			p++;
		end
		while (pin !== 1'b1 && p < 600) begin @(negedge clk); p++; end
	endtask

	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#800000;
		err_count++;
		final_report();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		wb(0, RCOUT_CTRL_OFS, 0, q);
		chk("ctrl reset", 32'h10, q);
		wb(0, RCOUT_SRC_OFS, 0, q);
		chk("src reset", 32'h0, q);
		chk("pin reset", 0, pin);
		wb(1, RCOUT_CTRL_OFS, 32'hFF, q);
		wb(0, RCOUT_CTRL_OFS, 0, q);
		chk("ctrl bits", 32'h9F, q);
		wsel = 4'hE;
		wb(1, RCOUT_CTRL_OFS, 32'h0, q);
		wsel = 4'hF;
		wb(1, 32'hC, 32'h0, q);
		wb(0, RCOUT_CTRL_OFS, 0, q);
		chk("lane ignore", 32'h9F, q);
		wb(0, 32'hC, 0, q);
		chk("unmapped", 32'h0, q);
		$display("register test done");
		foreach (rows[i]) begin
			c = {3'h0, rows[i].d, rows[i].r};
			wb(1, RCOUT_CTRL_OFS, {24'h0, c}, q);
			wb(1, RCOUT_CTRL_OFS, {24'h0, c | 8'h80}, q);
			meas(hi, per);
			chk("high", rows[i].hi, hi);
			chk("period", rows[i].per, per);
			$display("row %0d done", i);
		end
		wb(1, RCOUT_CTRL_OFS, 32'h3, q);
		wb(1, RCOUT_CTRL_OFS, 32'h83, q);
		r0 = rises;
		repeat (40) @(negedge clk);
		chk("duty zero", r0, rises);
		$display("duty zero test done");
		wb(1, RCOUT_CTRL_OFS, 32'h1B, q);
		wb(1, RCOUT_CTRL_OFS, 32'h9B, q);
		meas(hi, per);
		wb(1, RCOUT_CTRL_OFS, 32'h1B, q);
		@(negedge clk);
		chk("stop", 0, pin);
		wb(0, RCOUT_STAT_OFS, 0, q);
		chk("status off", 32'h0, q);
		$display("disable test done");
		wb(1, RCOUT_CTRL_OFS, 32'h92, q);
		repeat (3) @(posedge clk);
		slp <= 1'b1;
		@(negedge clk);
		held = pin;
		repeat (12) begin
			@(negedge clk);
			chk("sleep hold", held, pin);
		end
		wb(0, RCOUT_STAT_OFS, 0, q);
		q0 = q;
		wb(0, RCOUT_STAT_OFS, 0, q);
		chk("sleep status", q0, q);
		chk("sleep running", 1, q[RCOUT_STAT_RUN]);
		chk("sleep out bit", held, q[RCOUT_STAT_OUT]);
		@(posedge clk);
		slp <= 1'b0;
		wb(0, RCOUT_CTRL_OFS, 0, q);
		chk("sleep ctrl", 32'h92, q);
		meas(hi, per);
		chk("wake period", 8, per);
		$display("sleep test done");
		for (int s = 1; s < 6; s++) begin
			wb(1, RCOUT_CTRL_OFS, 32'h11, q);
			wb(1, RCOUT_SRC_OFS, s, q);
			wb(0, RCOUT_SRC_OFS, 0, q);
			if (s < 5) chk("src", s, q);
			r0 = rises;
			wb(1, RCOUT_CTRL_OFS, 32'h91, q);
			repeat (300) @(negedge clk);
			chk("ext run", s < 5, rises > r0);
			nr = rises - r0;
			chk("ext rate", 1, nr inside {[ext_exp[s]-1:ext_exp[s]+1]});
		end
		$display("source test done");
		wb(1, RCOUT_CTRL_OFS, 32'h08, q);
		wb(1, RCOUT_SRC_OFS, 32'h1, q);
		wb(1, RCOUT_CTRL_OFS, 32'h88, q);
		repeat (10) @(negedge clk);
		r0 = rises;
		repeat (300) @(negedge clk);
		// 300 cycles hold 100 periods of the 120 ns model oscillator
		nr = rises - r0;
		chk("undiv rises", 1, nr inside {[99:101]});
		$display("undivided test done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("reset pin", 0, pin);
		wb(0, RCOUT_CTRL_OFS, 0, q);
		chk("ctrl after reset", 32'h10, q);
		wb(0, RCOUT_SRC_OFS, 0, q);
		chk("src after reset", 32'h0, q);
		$display("reset test done");
		final_report();
	end
endmodule
